// [drive_out_sel.sv]
// drive output function select with axi4-lite registers
// Operation
// - any function may be assigned to any of five open-collector terminals.
// - relay defaults to alarm, yet accepts any terminal function.
// - code 00 asserts in run mode, deasserts in stop mode.
// - run indicator is active low, pulling terminal to common.
// - run indicator asserted while output frequency exceeds start frequency.
// - code 01 asserts once output frequency equals set frequency.
// - code 02 asserts accelerating at or above accel threshold one.
// - threshold outputs turn on and off at separate programmable frequencies.
// - arrival outputs use hysteresis against chatter on turn-off only; turn-on has none.
// - code 02 deasserts decelerating below decel threshold one minus hysteresis.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module drive_out_sel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_mode,
  input wire logic alarm_active,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic [15:0] output_frequency,
  output logic [4:0] term_out_n,
  output logic relay_out
);
  localparam int FW = drive_out_pkg::FREQ_W;
  localparam int CW = drive_out_pkg::FUNC_W;
  localparam int NS = drive_out_pkg::NUM_SEL;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rwait;
    logic rpend;
    logic [7:0] raddr;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] set_freq;
    logic [15:0] acc_thr;
    logic [15:0] dec_thr;
    logic [15:0] start_freq;
    logic [15:0] hyst;
    logic at_set;
    logic over_one;
    logic [4:0] term_n;
    logic relay;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [CW-1:0] sel_rd;
  logic [NS*CW-1:0] codes;
  logic sel_wr;

  // ==========================================
  // helpers
  function automatic logic fn_value(input logic [7:0] code, input logic run_ind,
                                    input logic at_set, input logic over_one,
                                    input logic alarm);
    case (code)
      drive_out_pkg::FUNC_RUN: fn_value = run_ind;
      drive_out_pkg::FUNC_AT_SET: fn_value = at_set;
      drive_out_pkg::FUNC_OVER_ONE: fn_value = over_one;
      drive_out_pkg::FUNC_ALARM: fn_value = alarm;
      default: fn_value = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] fn_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
    fn_merge = old;
    if (strb[0])
      fn_merge[7:0] = d[7:0];
    if (strb[1])
      fn_merge[15:8] = d[15:8];
  endfunction

  function automatic logic is_sel(input logic [7:0] a);
    is_sel = (a[1:0] == 2'h0) && (a < drive_out_pkg::OFF_SET_FREQ);
  endfunction

  // ==========================================
  // selection memory
  // one code each
  assign sel_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && is_sel(st_ff.awaddr);

  func_sel_mem #(
    .DEPTH(NS),
    .WIDTH(CW),
    .RELAY_DEFAULT(drive_out_pkg::FUNC_ALARM)
  ) u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(sel_wr),
    .wr_idx(st_ff.awaddr[4:2]),
    .wr_data(st_ff.wdata[7:0]),
    .rd_idx(st_ff.raddr[4:2]),
    .rd_data(sel_rd),
    .all_codes(codes)
  );

  assign s_axi_awready = !st_ff.aw_got;
  assign s_axi_wready = !st_ff.w_got;
  assign s_axi_arready = !st_ff.rwait && !st_ff.rpend && !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign term_out_n = st_ff.term_n;
  assign relay_out = st_ff.relay;

  // ==========================================
  // next state
  always_comb
  begin
    logic run_ind;
    logic wmap;
    logic [16:0] up_hi;
    logic [16:0] dn_lo;
    logic [16:0] f;
    run_ind = 1'b0;
    wmap = 1'b0;
    up_hi = '0;
    dn_lo = '0;
    f = {1'b0, output_frequency};
    nxt_st = st_ff;
    // write channel
    if (s_axi_awvalid && !st_ff.aw_got)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_ff.w_got)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      wmap = 1'b1;
      case (st_ff.awaddr)
        drive_out_pkg::OFF_SET_FREQ: nxt_st.set_freq = fn_merge(st_ff.set_freq, st_ff.wdata, s_axi_wstrb | 4'hf);
        drive_out_pkg::OFF_ACC_THR: nxt_st.acc_thr = fn_merge(st_ff.acc_thr, st_ff.wdata, 4'hf);
        drive_out_pkg::OFF_DEC_THR: nxt_st.dec_thr = fn_merge(st_ff.dec_thr, st_ff.wdata, 4'hf);
        drive_out_pkg::OFF_START_FREQ: nxt_st.start_freq = fn_merge(st_ff.start_freq, st_ff.wdata, 4'hf);
        drive_out_pkg::OFF_HYST: nxt_st.hyst = fn_merge(st_ff.hyst, st_ff.wdata, 4'hf);
        default: wmap = is_sel(st_ff.awaddr);
      endcase
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wmap ? drive_out_pkg::RESP_OKAY : drive_out_pkg::RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
    end
    // read channel: one cycle to present the index, one for the memory's registered data
    if (s_axi_arvalid && !st_ff.rwait && !st_ff.rpend && !st_ff.rvalid)
    begin
      nxt_st.rwait = 1'b1;
      nxt_st.raddr = s_axi_araddr[7:0];
    end
    if (st_ff.rwait)
    begin
      nxt_st.rwait = 1'b0;
      nxt_st.rpend = 1'b1;
    end
    if (st_ff.rpend)
    begin
      nxt_st.rpend = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = drive_out_pkg::RESP_OKAY;
      case (st_ff.raddr)
        drive_out_pkg::OFF_SET_FREQ: nxt_st.rdata = {16'h0000, st_ff.set_freq};
        drive_out_pkg::OFF_ACC_THR: nxt_st.rdata = {16'h0000, st_ff.acc_thr};
        drive_out_pkg::OFF_DEC_THR: nxt_st.rdata = {16'h0000, st_ff.dec_thr};
        drive_out_pkg::OFF_START_FREQ: nxt_st.rdata = {16'h0000, st_ff.start_freq};
        drive_out_pkg::OFF_HYST: nxt_st.rdata = {16'h0000, st_ff.hyst};
        drive_out_pkg::OFF_STATUS: nxt_st.rdata = {24'h000000, st_ff.relay,
                                       st_ff.over_one, st_ff.at_set, ~st_ff.term_n};
        default:
        begin
          nxt_st.rdata = is_sel(st_ff.raddr) ? {24'h000000, sel_rd} : 32'h00000000;
          nxt_st.rresp = is_sel(st_ff.raddr) ? drive_out_pkg::RESP_OKAY
                                             : drive_out_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    run_ind = run_mode && (output_frequency > st_ff.start_freq);
    up_hi = {1'b0, st_ff.set_freq} + {1'b0, st_ff.hyst};
    dn_lo = (st_ff.set_freq > st_ff.hyst) ? {1'b0, st_ff.set_freq - st_ff.hyst} : 17'h00000;
    if (f == {1'b0, st_ff.set_freq})
      nxt_st.at_set = 1'b1;
    else if (f > up_hi || f < dn_lo)
      nxt_st.at_set = 1'b0;
    if (accelerating && output_frequency >= st_ff.acc_thr)
      nxt_st.over_one = 1'b1;
    else if (decelerating && f + {1'b0, st_ff.hyst} < {1'b0, st_ff.dec_thr})
      nxt_st.over_one = 1'b0;
    else if (!run_mode)
      nxt_st.over_one = 1'b0;
    for (int i = 0; i < drive_out_pkg::NUM_TERM; i++)
      nxt_st.term_n[i] = ~fn_value(codes[i*CW +: CW], run_ind, st_ff.at_set,
                                   st_ff.over_one, alarm_active);
    nxt_st.relay = fn_value(codes[(NS-1)*CW +: CW], run_ind, st_ff.at_set,
                            st_ff.over_one, alarm_active);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.hyst <= drive_out_pkg::RST_HYST;
      st_ff.term_n <= '1;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================
  // checks
  a_run_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (codes[CW-1:0] == drive_out_pkg::FUNC_RUN && run_mode && output_frequency > st_ff.start_freq
     && $stable(codes)) |=> !term_out_n[0]) else $error("run not asserted low");
  a_stop_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (codes[CW-1:0] == drive_out_pkg::FUNC_RUN && !run_mode) |=> term_out_n[0])
    else $error("run asserted in stop");
  a_start_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (codes[CW-1:0] == drive_out_pkg::FUNC_RUN && output_frequency <= st_ff.start_freq)
    |=> term_out_n[0]) else $error("run below start frequency");
  a_at_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (output_frequency == st_ff.set_freq) |=> st_ff.at_set) else $error("setpoint missed");
  a_over_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (accelerating && output_frequency >= st_ff.acc_thr) |=> st_ff.over_one)
    else $error("accel threshold missed");
  a_over_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (!accelerating && decelerating && {1'b0, output_frequency} + {1'b0, st_ff.hyst}
     < {1'b0, st_ff.dec_thr}) |=> !st_ff.over_one) else $error("decel threshold missed");
  a_over_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!accelerating && !decelerating && run_mode) |=> $stable(st_ff.over_one))
    else $error("threshold output chatter");
  a_relay_dflt: assert property (@(posedge aclk) disable iff (!aresetn)
    (codes[(NS-1)*CW +: CW] == drive_out_pkg::FUNC_ALARM && alarm_active
     && $stable(codes)) |=> relay_out) else $error("relay alarm missing");
  a_bresp_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("bvalid dropped");
  c_run_on: cover property (@(posedge aclk) disable iff (!aresetn) !term_out_n[0]);
  c_at_set: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_ff.at_set));
  c_over_off: cover property (@(posedge aclk) disable iff (!aresetn) $fell(st_ff.over_one));
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// [drive_out_pkg.sv]
// package of constants for the drive output function select block
package drive_out_pkg;
  localparam int FREQ_W = 16;
  localparam int FUNC_W = 8;
  localparam int NUM_TERM = 5;
  localparam int NUM_SEL = 6;
  // function codes
  localparam logic [7:0] FUNC_RUN = 8'h00;
  localparam logic [7:0] FUNC_AT_SET = 8'h01;
  localparam logic [7:0] FUNC_OVER_ONE = 8'h02;
  localparam logic [7:0] FUNC_ALARM = 8'h05;
  // register byte offsets
  localparam logic [7:0] OFF_SEL_BASE = 8'h00;
  localparam logic [7:0] OFF_SET_FREQ = 8'h18;
  localparam logic [7:0] OFF_ACC_THR = 8'h1c;
  localparam logic [7:0] OFF_DEC_THR = 8'h20;
  localparam logic [7:0] OFF_START_FREQ = 8'h24;
  localparam logic [7:0] OFF_HYST = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  // reset values and bus response codes
  localparam logic [15:0] RST_HYST = 16'h0002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [func_sel_mem.sv]
// small memory of per-output function codes, registered read
`timescale 1ns/1ps
`default_nettype none
module func_sel_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 8,
  parameter logic [7:0] RELAY_DEFAULT = 8'h05
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  output logic [DEPTH*WIDTH-1:0] all_codes
);
  logic [DEPTH*WIDTH-1:0] mem_ff;
  logic [WIDTH-1:0] rd_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // relay slot defaults to alarm, terminals to run
      mem_ff <= '0;
      mem_ff[(DEPTH-1)*WIDTH +: WIDTH] <= RELAY_DEFAULT;
      rd_ff <= '0;
    end
    else
    begin
      if (wr_en && (32'(wr_idx) < DEPTH))
        mem_ff[wr_idx*WIDTH +: WIDTH] <= wr_data;
      rd_ff <= (32'(rd_idx) < DEPTH) ? mem_ff[rd_idx*WIDTH +: WIDTH] : '0;
    end
  end
  assign rd_data = rd_ff;
  assign all_codes = mem_ff;
endmodule
`default_nettype wire

// [ext_load.sv]
// model of the external load wired to the output terminals
`timescale 1ns/1ps
`default_nettype none
module ext_load (
  input wire logic [4:0] term_out_n,
  input wire logic relay_out,
  output logic [5:0] energised
);
  // ==========
  // load side
  // pulled up to supply: a released terminal reads high, so only a sink energises
  // active low sink
  assign energised = {relay_out, ~term_out_n};
endmodule
`default_nettype wire

// [drive_output_function_select_test.sv]
// self-checking bench for the drive output function select block
`timescale 1ns/1ps
`default_nettype none
module drive_output_function_select_test;
  // ==========
  // signals
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic run_mode, alarm_active, accelerating, decelerating, relay_out, run_ind, at_set, over_one;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] output_frequency, start;
  logic [4:0] term_out_n;
  logic [5:0] energised;
  logic [7:0] codes [6];
  logic [33:0] exp_q [$];
  int n_errors, n_checks, cycles;
  localparam logic [7:0] pick [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h07};
  // run, accel, decel / frequency / at-setpoint, over-one
  localparam logic [20:0] steps [12] = '{{3'b100, 16'h03e8, 2'b10}, {3'b100, 16'h03e9, 2'b10},
    {3'b100, 16'h03eb, 2'b00}, {3'b100, 16'h03e9, 2'b00}, {3'b100, 16'h03e8, 2'b10},
    {3'b110, 16'h01f3, 2'b00}, {3'b110, 16'h01f4, 2'b01}, {3'b101, 16'h0190, 2'b01},
    {3'b101, 16'h012a, 2'b01}, {3'b101, 16'h0129, 2'b00}, {3'b110, 16'h01f5, 2'b01},
    {3'b000, 16'h01f5, 2'b00}};

  drive_out_sel i_drive_out_sel (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .run_mode, .alarm_active, .accelerating, .decelerating, .output_frequency,
    .term_out_n, .relay_out
  );
  ext_load i_ext_load (.term_out_n, .relay_out, .energised);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========
  // checking
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // look half a cycle early: what stands here is what the next rising edge takes
  always @(negedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      cmp({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] exp_status();
    logic [5:0] on;
    for (int i = 0; i < 6; i++)
    begin
      case (codes[i])
        drive_out_pkg::FUNC_RUN: on[i] = run_ind;
        drive_out_pkg::FUNC_AT_SET: on[i] = at_set;
        drive_out_pkg::FUNC_OVER_ONE: on[i] = over_one;
        drive_out_pkg::FUNC_ALARM: on[i] = alarm_active;
        default: on[i] = 1'b0;
      endcase
    end
    return {on[5], over_one, at_set, on[4:0]};
  endfunction

  // ==========
  // bus tasks
  // ready is settled at the falling edge, the transfer happens at the next rising one
  task automatic wait_hi(ref logic s);
    do
    begin
      @(negedge aclk);
    end while (s !== 1'b1);
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic da, dw;
    exp_q.push_back({resp, 32'h0});
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      da = da | s_axi_awready;
      dw = dw | s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end while (!(da && dw));
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic apply(input logic [2:0] m, input logic [15:0] f, input logic [1:0] e);
    logic [7:0] s;
    @(posedge aclk);
    run_mode <= m[2];
    accelerating <= m[1];
    decelerating <= m[0];
    output_frequency <= f;
    alarm_active <= 1'($urandom_range(0, 1));
    repeat (4) @(posedge aclk);
    run_ind = m[2] && (f > start);
    at_set = e[1];
    over_one = e[0];
    s = exp_status();
    @(negedge aclk);
    cmp({28'h0, energised}, {28'h0, s[7], s[4:0]});
    rd(drive_out_pkg::OFF_STATUS, {26'h0, s});
  endtask

  // ==========
  // sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {run_mode, alarm_active, accelerating, decelerating} = 4'h0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    output_frequency = 16'h0010;
    aresetn = 1'b0;
    start = 16'h0;
    codes = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
    void'($urandom(32'habd5eb80));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), {26'h0, codes[i]});
    rd(drive_out_pkg::OFF_HYST, {18'h0, drive_out_pkg::RST_HYST});
    rd(8'h30, {drive_out_pkg::RESP_SLVERR, 32'h0});
    wr(8'h30, $urandom(), drive_out_pkg::RESP_SLVERR);
    start = 16'h0100 + 16'($urandom_range(0, 32));
    wr(drive_out_pkg::OFF_START_FREQ, {16'h0, start}, drive_out_pkg::RESP_OKAY);
    apply(3'b100, start + 16'h1, 2'b00);
    apply(3'b100, start, 2'b00);
    apply(3'b000, start + 16'h9, 2'b00);
    apply(3'b100, start + 16'h2 + 16'($urandom_range(0, 999)), 2'b00);
    wr(drive_out_pkg::OFF_SET_FREQ, 32'h3e8, drive_out_pkg::RESP_OKAY);
    wr(drive_out_pkg::OFF_ACC_THR, 32'h1f4, drive_out_pkg::RESP_OKAY);
    wr(drive_out_pkg::OFF_DEC_THR, 32'h12c, drive_out_pkg::RESP_OKAY);
    for (int k = 0; k < 12; k++)
      apply(steps[k][20:18], steps[k][17:2], steps[k][1:0]);
    // random routing, relay included, may replace the default alarm code with any picked code
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        codes[i] = pick[$urandom_range(0, 4)];
        wr(8'(4 * i), {24'h0, codes[i]}, drive_out_pkg::RESP_OKAY);
        rd(8'(4 * i), {26'h0, codes[i]});
      end
      apply(3'b100, 16'h03e8, 2'b10);
    end
    complete_run();
  end
endmodule
`default_nettype wire
